/* File: core/flash_cmd_pkg.sv */
// What this block does
// R1: sequence violation sets access error bit 4 and drops the offending command
// R2: program or erase before divider written sets access error and is refused
// R3: stop entry while a command runs sets access error
// R4: access error clears only on writing one; reads one after an error
// R5: blank check end sets blank-verified bit 2 only if whole array erased
// R6: blank-verified clears on a valid launch; direct writes do nothing
// R7: after blank check with complete set, blank-verified reflects erased array
// R8: six legal codes; blank check 05, byte program 20, burst program 25
// R9: sector erase 40, mass erase 41, sector erase abort 47
// R10: any other code is illegal, never runs, sets access error
// R11: software needs blank check only for unlocking, not after mass erase
// R12: writing one to buffer-empty launches; both flags clear until operation ends
package flash_cmd_pkg;
    localparam int ADDR_W = 3;
    localparam logic [2:0] OFF_DIVIDER = 3'h0;
    localparam logic [2:0] OFF_STATUS = 3'h1;
    localparam logic [2:0] OFF_COMMAND = 3'h2;
    localparam logic [2:0] OFF_IRQ_STATUS = 3'h3;
    localparam logic [2:0] OFF_IRQ_MASK = 3'h4;
    localparam int BIT_CBEF = 7;
    localparam int BIT_CCF = 6;
    localparam int BIT_ACCERR = 4;
    localparam int BIT_BLANK = 2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam logic [7:0] RST_DIVIDER = 8'h00;
    localparam logic [7:0] RST_COMMAND = 8'h00;
    localparam logic [1:0] RST_IRQ_MASK = 2'h0;
    localparam logic [7:0] CMD_BLANK_CHECK = 8'h05;
    localparam logic [7:0] CMD_BYTE_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_BURST_PROGRAM = 8'h25;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;
    localparam logic [7:0] CMD_ERASE_ABORT = 8'h47;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOADED = 2'b01,
        ST_BUSY = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic cbef;
        logic ccf;
        logic accerr;
        logic blank;
    } status_t;
endpackage : flash_cmd_pkg

/* File: core/flash_command_status_logic.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_command_status_logic (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rd_data,
    input wire logic stop_entry,
    input wire logic op_done,
    input wire logic array_erased,
    output logic op_start,
    output logic [7:0] op_code,
    output logic op_abort,
    output logic irq
);
    logic rst_s1_q;
    logic rst_sync_n_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_sync_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_sync_n_q <= rst_s1_q;
        end
    end

    flash_cmd_pkg::seq_state_t state_q;
    flash_cmd_pkg::status_t stat_q;
    logic [7:0] divider_q;
    logic div_written_q;
    logic [7:0] cmd_q;
    logic [7:0] run_code_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [7:0] rd_data_q;
    logic op_start_q;
    logic op_abort_q;
    logic irq_q;

    logic wr_div;
    logic wr_stat;
    logic wr_cmd;
    logic launch;
    logic legal;
    logic needs_div;
    logic launch_ok;
    logic abort_ok;
    logic seq_err;
    logic err_set;
    logic done_evt;
    logic wr_irq_stat;
    logic wr_irq_mask;
    wire logic [1:0] irq_stat_d;

    assign wr_div = wr_stb && (addr == flash_cmd_pkg::OFF_DIVIDER);
    assign wr_stat = wr_stb && (addr == flash_cmd_pkg::OFF_STATUS);
    assign wr_cmd = wr_stb && (addr == flash_cmd_pkg::OFF_COMMAND);
    assign launch = wr_stat && wr_data[flash_cmd_pkg::BIT_CBEF];
    assign wr_irq_stat = wr_stb && (addr == flash_cmd_pkg::OFF_IRQ_STATUS);
    assign wr_irq_mask = wr_stb && (addr == flash_cmd_pkg::OFF_IRQ_MASK);

    always_comb begin
        case (cmd_q) // [R8] [R9]
            flash_cmd_pkg::CMD_BLANK_CHECK,
            flash_cmd_pkg::CMD_BYTE_PROGRAM,
            flash_cmd_pkg::CMD_BURST_PROGRAM,
            flash_cmd_pkg::CMD_SECTOR_ERASE,
            flash_cmd_pkg::CMD_MASS_ERASE,
            flash_cmd_pkg::CMD_ERASE_ABORT: legal = 1'b1;
            default: legal = 1'b0; // [R10]
        endcase
    end

    // blank check only reads, so it runs without a divider setting
    assign needs_div = (cmd_q != flash_cmd_pkg::CMD_BLANK_CHECK);
    // abort alone is meaningful while a sector erase runs
    assign abort_ok = (state_q == flash_cmd_pkg::ST_BUSY) && wr_cmd
        && (wr_data == flash_cmd_pkg::CMD_ERASE_ABORT)
        && (run_code_q == flash_cmd_pkg::CMD_SECTOR_ERASE);
    assign launch_ok = launch && (state_q == flash_cmd_pkg::ST_LOADED) && legal
        && (cmd_q != flash_cmd_pkg::CMD_ERASE_ABORT)
        && !stat_q.accerr && (div_written_q || !needs_div); // [R2] [R10]

    always_comb begin
        seq_err = 1'b0;
        case (state_q)
            flash_cmd_pkg::ST_IDLE: seq_err = launch; // [R1] launch with nothing loaded
            flash_cmd_pkg::ST_LOADED: seq_err = launch && !launch_ok; // [R1] [R2] [R10]
            flash_cmd_pkg::ST_BUSY: seq_err = (wr_cmd && !abort_ok) || launch; // [R1]
            default: seq_err = 1'b0;
        endcase
    end

    assign err_set = seq_err || (stop_entry && state_q == flash_cmd_pkg::ST_BUSY); // [R3]
    assign done_evt = (state_q == flash_cmd_pkg::ST_BUSY) && op_done;

    always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            state_q <= flash_cmd_pkg::ST_IDLE;
            cmd_q <= flash_cmd_pkg::RST_COMMAND;
            run_code_q <= flash_cmd_pkg::RST_COMMAND;
        end else begin
            case (state_q)
                flash_cmd_pkg::ST_IDLE: begin
                    if (wr_cmd && !stat_q.accerr) begin
                        cmd_q <= wr_data;
                        state_q <= flash_cmd_pkg::ST_LOADED;
                    end
                end
                flash_cmd_pkg::ST_LOADED: begin
                    if (wr_cmd) begin
                        cmd_q <= wr_data;
                    end else if (launch_ok) begin
                        run_code_q <= cmd_q;
                        state_q <= flash_cmd_pkg::ST_BUSY; // [R12]
                    end else if (launch) begin
                        state_q <= flash_cmd_pkg::ST_IDLE; // [R1] offending command dropped
                    end
                end
                flash_cmd_pkg::ST_BUSY: begin
                    if (op_done) begin
                        state_q <= flash_cmd_pkg::ST_IDLE;
                    end
                end
                default: state_q <= flash_cmd_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            stat_q.cbef <= 1'b1;
            stat_q.ccf <= 1'b1;
            stat_q.accerr <= 1'b0;
            stat_q.blank <= 1'b0;
        end else begin
            if (launch_ok) begin
                stat_q.cbef <= 1'b0; // [R12]
                stat_q.ccf <= 1'b0; // [R12]
                stat_q.blank <= 1'b0; // [R6]
            end else if (done_evt) begin
                stat_q.cbef <= 1'b1; // [R12]
                stat_q.ccf <= 1'b1; // [R12]
                if (run_code_q == flash_cmd_pkg::CMD_BLANK_CHECK) begin
                    stat_q.blank <= array_erased; // [R5] [R7]
                end
            end
            // set beats a same-cycle write-one clear
            if (err_set) begin
                stat_q.accerr <= 1'b1; // [R1] [R3]
            end else if (wr_stat && wr_data[flash_cmd_pkg::BIT_ACCERR]) begin
                stat_q.accerr <= 1'b0; // [R4]
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            divider_q <= flash_cmd_pkg::RST_DIVIDER;
            div_written_q <= 1'b0;
        end else if (wr_div) begin
            divider_q <= wr_data;
            div_written_q <= 1'b1; // [R2]
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            op_start_q <= 1'b0;
            op_abort_q <= 1'b0;
        end else begin
            op_start_q <= launch_ok;
            op_abort_q <= abort_ok || (stop_entry && state_q == flash_cmd_pkg::ST_BUSY);
        end
    end

    // set wins over a same-cycle write-one clear, so no event is lost
    for (genvar i = 0; i < 2; i++) begin : g_irq_bit
        assign irq_stat_d[i] = ((i == flash_cmd_pkg::IRQ_DONE) && done_evt)
            || ((i == flash_cmd_pkg::IRQ_ERR) && err_set)
            || (irq_stat_q[i] && !(wr_irq_stat && wr_data[i]));
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            irq_stat_q <= 2'h0;
            irq_mask_q <= flash_cmd_pkg::RST_IRQ_MASK;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= irq_stat_d;
            if (wr_irq_mask) begin
                irq_mask_q <= wr_data[1:0];
            end
            // registered so the pin never glitches; costs one cycle of latency
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
        if (!rst_sync_n_q) begin
            rd_data_q <= 8'h00;
        end else if (rd_stb) begin
            case (addr)
                flash_cmd_pkg::OFF_DIVIDER: rd_data_q <= divider_q;
                flash_cmd_pkg::OFF_STATUS: begin
                    rd_data_q <= 8'h00;
                    rd_data_q[flash_cmd_pkg::BIT_CBEF] <= stat_q.cbef;
                    rd_data_q[flash_cmd_pkg::BIT_CCF] <= stat_q.ccf;
                    rd_data_q[flash_cmd_pkg::BIT_ACCERR] <= stat_q.accerr; // [R4]
                    rd_data_q[flash_cmd_pkg::BIT_BLANK] <= stat_q.blank; // [R7]
                end
                flash_cmd_pkg::OFF_COMMAND: rd_data_q <= cmd_q;
                flash_cmd_pkg::OFF_IRQ_STATUS: rd_data_q <= {6'h00, irq_stat_q};
                flash_cmd_pkg::OFF_IRQ_MASK: rd_data_q <= {6'h00, irq_mask_q};
                default: rd_data_q <= 8'h00;
            endcase
        end else begin
            rd_data_q <= 8'h00;
        end
    end

    assign rd_data = rd_data_q;
    assign op_start = op_start_q;
    assign op_code = run_code_q;
    assign op_abort = op_abort_q;
    assign irq = irq_q;
endmodule : flash_command_status_logic
`default_nettype wire

/* File: testbench/flash_cmd_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_properties (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [flash_cmd_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [7:0] rd_data,
    input wire logic stop_entry,
    input wire logic op_done,
    input wire logic array_erased,
    input wire logic op_start,
    input wire logic [7:0] op_code,
    input wire logic op_abort,
    input wire logic irq
);
    logic busy_q;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    // lags the design by one cycle, so no check fires on the launch edge itself
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) busy_q <= 1'b0;
        else if (op_start) busy_q <= 1'b1;
        else if (op_done) busy_q <= 1'b0;
    end
    a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
        else $error("read data outside read slot");
    a_start_pulse: assert property (op_start |=> !op_start)
        else $error("start longer than one cycle");
    a_start_cause: assert property (op_start |-> $past(wr_stb && addr == flash_cmd_pkg::OFF_STATUS
        && wr_data[flash_cmd_pkg::BIT_CBEF])) else $error("start without launch");
    a_start_legal: assert property (op_start |-> op_code inside {8'h05, 8'h20, 8'h25,
        8'h40, 8'h41}) else $error("illegal code started");
    a_stop_abort: assert property (busy_q && stop_entry && !op_done |=> op_abort)
        else $error("stop while busy not aborted");
    a_abort_cause: assert property (op_abort |-> $past(stop_entry || wr_stb))
        else $error("abort without cause");
    a_code_hold: assert property ($changed(op_code) |-> op_start)
        else $error("code changed without start");
    a_unmapped_rd: assert property (rd_stb && addr > flash_cmd_pkg::OFF_IRQ_MASK |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
endmodule : flash_cmd_properties
bind flash_command_status_logic flash_cmd_properties u_props (.core_clk(core_clk), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .stop_entry(stop_entry), .op_done(op_done), .array_erased(array_erased), .op_start(op_start),
    .op_code(op_code), .op_abort(op_abort), .irq(irq));
`default_nettype wire

/* File: testbench/test_flash_command_status_logic.sv */
`timescale 1ns/10ps
`default_nettype none
module test_flash_command_status_logic;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wr_data = 8'h00;
    logic wr_stb = 1'b0, rd_stb = 1'b0, stop_entry = 1'b0, op_done = 1'b0, array_erased = 1'b0;
    logic [7:0] rd_data, op_code;
    logic op_start, op_abort, irq;
    int err_count = 0, checks = 0, starts = 0, aborts = 0;
    logic [7:0] codes[$] = '{8'h05, 8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    always #25 core_clk = ~core_clk;
    flash_command_status_logic u_dut (.core_clk(core_clk), .rst_n(rst_n), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .stop_entry(stop_entry), .op_done(op_done), .array_erased(array_erased),
        .op_start(op_start), .op_code(op_code), .op_abort(op_abort), .irq(irq));
    always @(posedge core_clk) begin
        starts += int'(op_start);
        aborts += int'(op_abort);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        chk(rd_data, exp);
    endtask : rd
    task automatic rs(input logic [7:0] exp);
        rd(flash_cmd_pkg::OFF_STATUS, exp);
    endtask : rs
    task automatic launch(input logic [7:0] c);
        wr(flash_cmd_pkg::OFF_COMMAND, c);
        wr(flash_cmd_pkg::OFF_STATUS, 8'h80);
    endtask : launch
    task automatic done(input logic e);
        @(posedge core_clk);
        op_done <= 1'b1;
        array_erased <= e;
        @(posedge core_clk);
        op_done <= 1'b0;
    endtask : done
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        err_count++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] c;
        int a0;
        void'($urandom(32'h735e));
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rs(8'hc0);
        rd(flash_cmd_pkg::OFF_IRQ_MASK, 8'h00);
        rd(3'h7, 8'h00);
        launch(8'h20);
        rs(8'hd0);
        chk({7'h0, irq}, 8'h00);
        wr(flash_cmd_pkg::OFF_IRQ_MASK, 8'h02);
        repeat (2) @(posedge core_clk);
        chk({7'h0, irq}, 8'h01);
        wr(flash_cmd_pkg::OFF_IRQ_STATUS, 8'h03);
        repeat (2) @(posedge core_clk);
        chk({7'h0, irq}, 8'h00);
        wr(flash_cmd_pkg::OFF_STATUS, 8'h04);
        rs(8'hd0);
        wr(flash_cmd_pkg::OFF_STATUS, 8'h10);
        rs(8'hc0);
        // the failed launch above dropped its command, so nothing is loaded now
        wr(flash_cmd_pkg::OFF_STATUS, 8'h80);
        rs(8'hd0);
        wr(flash_cmd_pkg::OFF_STATUS, 8'h10);
        $display("test errors done");
        wr(flash_cmd_pkg::OFF_DIVIDER, 8'($urandom));
        foreach (codes[i]) begin
            array_erased <= (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : 1'($urandom);
            launch(codes[i]);
            rs(8'h00);
            chk(op_code, codes[i]);
            done(array_erased);
            rs((codes[i] == 8'h05 && array_erased) ? 8'hc4 : 8'hc0);
        end
        $display("test legal codes done");
        repeat (4) begin
            c = 8'($urandom);
            if (c inside {8'h05, 8'h20, 8'h25, 8'h40, 8'h41, 8'h47})
                c = c ^ 8'h80;
            launch(c);
            rs(8'hd0);
            wr(flash_cmd_pkg::OFF_STATUS, 8'h10);
        end
        launch(8'h47);
        rs(8'hd0);
        wr(flash_cmd_pkg::OFF_STATUS, 8'h10);
        $display("test illegal codes done");
        launch(8'h40);
        // abort is a command write alone; a launch while busy would be an access error
        wr(flash_cmd_pkg::OFF_COMMAND, 8'h47);
        rs(8'h00);
        chk(8'(aborts), 8'h01);
        done(1'b0);
        rs(8'hc0);
        a0 = aborts;
        launch(8'h41); // no blank check follows this mass erase
        @(posedge core_clk);
        stop_entry <= 1'b1;
        @(posedge core_clk);
        stop_entry <= 1'b0;
        rs(8'h10);
        chk(8'(aborts - a0), 8'h01);
        done(1'b0);
        rs(8'hd0);
        chk(8'(starts), 8'h08);
        $display("test abort and stop done");
        tally_and_finish();
    end
endmodule : test_flash_command_status_logic
`default_nettype wire
